// ---- logic/apsm_pkg.sv ----
// Package with constants, register map and types for the audio power-state manager
package apsm_pkg;

	// Register byte offsets
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] CMD_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h008;
	localparam logic [11:0] TIMER_OFFSET = 12'h00c;

	// Control register fields
	localparam int CTRL_RETAIN_EN_BIT = 0;
	localparam int CTRL_WAKE_EN_BIT = 1;
	localparam int CTRL_LOW_PRIO_BIT = 2;
	localparam int CTRL_PLAY_BIT = 3;
	localparam int CTRL_RECORD_BIT = 4;

	// Command register fields, each a write-one pulse
	localparam int CMD_OPEN_BIT = 0;
	localparam int CMD_CLOSE_BIT = 1;
	localparam int CMD_PAUSE_BIT = 2;
	localparam int CMD_RESUME_BIT = 3;
	localparam int CMD_POWER_DOWN_BIT = 4;
	localparam int CMD_WAKE_BIT = 5;

	// Low-power transition latency bound
	localparam int TRANSITION_MS = 100;
	localparam int CLK_HZ = 40000000;
	localparam int TRANSITION_CYCLES = (TRANSITION_MS * (CLK_HZ / 1000));

	// Reset values
	localparam logic [31:0] TIMER_RESET = 32'h0000_1000;
	localparam logic [4:0] CTRL_RESET = 5'h01;

	typedef enum logic [1:0] {
		FULL_ON_STATE = 2'b00,
		RETAIN_LOW_POWER_STATE = 2'b01,
		LOSSY_LOW_POWER_STATE = 2'b10,
		OFF_STATE = 2'b11
	} apsm_power_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apsm_apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apsm_apb_rsp_type;

	typedef struct packed {
		apsm_power_type power;
		logic [4:0] ctrl;
		logic paused;
		logic is_open;
		logic timer_run;
		logic [31:0] timer_load;
		logic [31:0] timer_cnt;
		logic save_pend;
		logic save_req;
		logic ctx_hold;
		logic wake;
		logic refused;
		logic pause_ignored;
		logic [31:0] prdata;
		logic pslverr;
	} apsm_state_type;

endpackage

// ---- logic/apsm_top.sv ----
// Audio device power-state manager with APB register access
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module apsm_top import apsm_pkg::*; (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire apsm_apb_req_type I_APB,
	output apsm_apb_rsp_type O_APB,
	input wire logic I_SAVE_DONE,
	output logic [1:0] O_POWER_STATE,
	output logic O_CTX_HOLD,
	output logic O_SAVE_REQ,
	output logic O_WAKE
);

	apsm_state_type state_reg;
	apsm_state_type state_next;

	logic wr_en;
	logic rd_en;
	logic cmd_open;
	logic cmd_close;
	logic cmd_pause;
	logic cmd_resume;
	logic cmd_pdown;
	logic cmd_wake;
	logic background;
	logic foreground;
	logic active;

	// Bus strobes; the slave always answers in the first access cycle
	assign wr_en = I_APB.psel && I_APB.penable && I_APB.pwrite;
	assign rd_en = I_APB.psel && I_APB.penable && !I_APB.pwrite;
	assign cmd_open = wr_en && (I_APB.paddr == CMD_OFFSET) && I_APB.pwdata[CMD_OPEN_BIT];
	assign cmd_close = wr_en && (I_APB.paddr == CMD_OFFSET) && I_APB.pwdata[CMD_CLOSE_BIT];
	assign cmd_pause = wr_en && (I_APB.paddr == CMD_OFFSET) && I_APB.pwdata[CMD_PAUSE_BIT];
	assign cmd_resume = wr_en && (I_APB.paddr == CMD_OFFSET) && I_APB.pwdata[CMD_RESUME_BIT];
	assign cmd_pdown = wr_en && (I_APB.paddr == CMD_OFFSET) && I_APB.pwdata[CMD_POWER_DOWN_BIT];
	assign cmd_wake = wr_en && (I_APB.paddr == CMD_OFFSET) && I_APB.pwdata[CMD_WAKE_BIT];

	// Activity classification; a playing stream pre-empts background capture
	assign active = state_reg.ctrl[CTRL_PLAY_BIT] || state_reg.ctrl[CTRL_RECORD_BIT];
	assign foreground = state_reg.ctrl[CTRL_PLAY_BIT] ||
		(state_reg.ctrl[CTRL_RECORD_BIT] && !state_reg.ctrl[CTRL_LOW_PRIO_BIT]);
	assign background = state_reg.ctrl[CTRL_RECORD_BIT] && state_reg.ctrl[CTRL_LOW_PRIO_BIT] &&
		!state_reg.ctrl[CTRL_PLAY_BIT];

	// Next-state logic for power state, timer, registers and bus answer
	always_comb begin
		state_next = state_reg;
		state_next.refused = 1'b0;
		state_next.pause_ignored = 1'b0;
		state_next.pslverr = 1'b0;
		// Register writes
		if (wr_en && I_APB.paddr == CTRL_OFFSET) begin
			state_next.ctrl = I_APB.pwdata[4:0];
		end
		if (wr_en && I_APB.paddr == TIMER_OFFSET) begin
			state_next.timer_load = I_APB.pwdata;
		end
		// Inactivity timer counts down while running
		if (state_reg.timer_run && state_reg.timer_cnt != 32'h0000_0000) begin
			state_next.timer_cnt = state_reg.timer_cnt - 32'h0000_0001;
		end
		// Wait for context save before dropping to off
		if (state_reg.save_pend && I_SAVE_DONE) begin
			state_next.save_pend = 1'b0;
			state_next.save_req = 1'b0;
			state_next.ctx_hold = 1'b0;
			// Paused stays set so a later resume can bring the device back up
			state_next.power = OFF_STATE;
		end
		unique case (state_reg.power)
			FULL_ON_STATE: begin
				if (cmd_pause) begin
					if (foreground) begin
						state_next.paused = 1'b1;
						state_next.ctx_hold = state_reg.ctrl[CTRL_RETAIN_EN_BIT];
						state_next.power = state_reg.ctrl[CTRL_RETAIN_EN_BIT] ?
							RETAIN_LOW_POWER_STATE : LOSSY_LOW_POWER_STATE;
					end else begin
						state_next.pause_ignored = 1'b1;
					end
				end else if (cmd_close) begin
					state_next.is_open = 1'b0;
					state_next.power = LOSSY_LOW_POWER_STATE;
					state_next.timer_run = 1'b1;
					state_next.timer_cnt = state_reg.timer_load;
				end else if (cmd_pdown) begin
					if (background) begin
						state_next.power = OFF_STATE;
					end else begin
						state_next.refused = 1'b1;
					end
				end else if (cmd_open) begin
					state_next.is_open = 1'b1;
				end
			end
			RETAIN_LOW_POWER_STATE, LOSSY_LOW_POWER_STATE: begin
				if (state_reg.save_pend) begin
					state_next.power = state_next.power; // Hold until save completes
				end else if (cmd_resume && state_reg.paused) begin
					state_next.paused = 1'b0;
					state_next.ctx_hold = 1'b0;
					state_next.power = FULL_ON_STATE;
				end else if (cmd_pdown && state_reg.paused) begin
					state_next.save_pend = 1'b1;
					state_next.save_req = 1'b1;
				end else if (cmd_open && !state_reg.paused) begin
					state_next.is_open = 1'b1;
					state_next.timer_run = 1'b0;
					state_next.power = FULL_ON_STATE;
				end else if (!state_reg.paused && state_reg.timer_run &&
					state_reg.timer_cnt == 32'h0000_0000) begin
					state_next.timer_run = 1'b0;
					state_next.power = OFF_STATE;
				end
			end
			OFF_STATE: begin
				// Power-up may take as long as needed; this end does it in one step
				if (cmd_open && !state_reg.is_open) begin
					state_next.is_open = 1'b1;
					state_next.power = FULL_ON_STATE;
				end else if (cmd_resume && state_reg.paused) begin
					state_next.paused = 1'b0;
					state_next.power = FULL_ON_STATE;
				end
			end
		endcase
		// Other commands fall through with no power change
		// Wake event is sticky until software disables it
		if (cmd_wake && state_reg.ctrl[CTRL_WAKE_EN_BIT]) begin
			state_next.wake = 1'b1;
		end else if (!state_reg.ctrl[CTRL_WAKE_EN_BIT]) begin
			state_next.wake = 1'b0;
		end
		// Read data
		state_next.prdata = 32'h0000_0000;
		if (rd_en) begin
			unique case (I_APB.paddr)
				CTRL_OFFSET: state_next.prdata = {27'h0000000, state_reg.ctrl};
				CMD_OFFSET: state_next.prdata = 32'h0000_0000;
				STATUS_OFFSET: state_next.prdata = {22'h000000, state_reg.pause_ignored,
					state_reg.refused, state_reg.wake, state_reg.save_pend, active,
					state_reg.timer_run, state_reg.paused, state_reg.is_open, state_reg.power};
				TIMER_OFFSET: state_next.prdata = state_reg.timer_cnt;
				default: state_next.pslverr = 1'b1;
			endcase
		end else if (wr_en && I_APB.paddr != CTRL_OFFSET && I_APB.paddr != CMD_OFFSET &&
			I_APB.paddr != TIMER_OFFSET) begin
			state_next.pslverr = 1'b1;
		end
	end

	// State register with synchronous reset
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			state_reg <= '0;
			state_reg.power <= OFF_STATE;
			state_reg.ctrl <= CTRL_RESET;
			state_reg.timer_load <= TIMER_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Bus answer is combinational: ready in the access cycle, data from that cycle's decode
	always_comb begin
		O_APB.pready = 1'b1;
		O_APB.pslverr = state_next.pslverr && I_APB.psel && I_APB.penable;
		O_APB.prdata = state_next.prdata;
	end

	assign O_POWER_STATE = state_reg.power;
	assign O_CTX_HOLD = state_reg.ctx_hold;
	assign O_SAVE_REQ = state_reg.save_req;
	assign O_WAKE = state_reg.wake;

endmodule // apsm_top

// ---- testbench/apsm_props.sv ----
// Port-level checker of the power-state manager
`timescale 1ns/1ps
module apsm_props import apsm_pkg::*; (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire apsm_apb_req_type I_APB,
	input wire apsm_apb_rsp_type O_APB,
	input wire logic I_SAVE_DONE,
	input wire logic [1:0] O_POWER_STATE,
	input wire logic O_CTX_HOLD,
	input wire logic O_SAVE_REQ,
	input wire logic O_WAKE
);
	logic wr;
	logic [5:0] cmd;
	logic [4:0] ctrl_reg;
	logic act;
	logic bg;
	logic on;
	// Shadow of the control word, so no design internals are probed
	assign wr = I_APB.psel & I_APB.penable & I_APB.pwrite;
	assign cmd = (wr & (I_APB.paddr == CMD_OFFSET)) ? I_APB.pwdata[5:0] : 6'h00;
	assign act = ctrl_reg[3] | (ctrl_reg[4] & ~ctrl_reg[2]);
	assign bg = ctrl_reg[4] & ctrl_reg[2] & ~ctrl_reg[3];
	assign on = O_POWER_STATE == FULL_ON_STATE;
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N)
			ctrl_reg <= CTRL_RESET;
		else if (wr & (I_APB.paddr == CTRL_OFFSET))
			ctrl_reg <= I_APB.pwdata[4:0];
	end
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);
	// Single-bit commands only; mixed bits follow a priority left to the design
	retain_entry_a: assert property (on && cmd == 6'h04 && act && ctrl_reg[0]
		|=> O_POWER_STATE == RETAIN_LOW_POWER_STATE && O_CTX_HOLD) else $error("no retain");
	lossy_pause_a: assert property (on && cmd == 6'h04 && act && !ctrl_reg[0]
		|=> O_POWER_STATE == LOSSY_LOW_POWER_STATE) else $error("no lossy pause");
	resume_on_a: assert property (O_CTX_HOLD && cmd == 6'h08
		|=> on && !O_CTX_HOLD) else $error("no resume");
	close_lossy_a: assert property (on && cmd == 6'h02
		|=> O_POWER_STATE == LOSSY_LOW_POWER_STATE) else $error("no close");
	off_refused_a: assert property (on && cmd == 6'h10 && !bg |=> on)
		else $error("off not refused");
	bg_off_a: assert property (on && cmd == 6'h10 && bg |=> O_POWER_STATE == OFF_STATE)
		else $error("no bg off");
	saved_off_a: assert property (O_SAVE_REQ && I_SAVE_DONE
		|=> O_POWER_STATE == OFF_STATE && !O_SAVE_REQ) else $error("no saved off");
	wake_raise_a: assert property (cmd == 6'h20 && ctrl_reg[1] |=> O_WAKE)
		else $error("no wake");
	cover property (on ##1 O_CTX_HOLD);
	cover property (O_SAVE_REQ && I_SAVE_DONE);
	cover property (on && cmd == 6'h10 && bg);
endmodule // apsm_props

bind apsm_top apsm_props u_props (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_APB(I_APB),
	.O_APB(O_APB), .I_SAVE_DONE(I_SAVE_DONE), .O_POWER_STATE(O_POWER_STATE),
	.O_CTX_HOLD(O_CTX_HOLD), .O_SAVE_REQ(O_SAVE_REQ), .O_WAKE(O_WAKE));

// ---- testbench/apsm_top_tb.sv ----
// Scenario bench for the power-state manager
`timescale 1ns/1ps
module apsm_top_tb import apsm_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic done = 1'b0;
	apsm_apb_req_type req = '0;
	apsm_apb_rsp_type rsp;
	logic [1:0] pwr;
	logic hold;
	logic sreq;
	logic wake;
	logic err;
	int fail_count = 0;
	int tests_run = 0;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	apsm_top uut (.I_CLK(clk), .I_RST_N(rst_n), .I_APB(req), .O_APB(rsp), .I_SAVE_DONE(done),
		.O_POWER_STATE(pwr), .O_CTX_HOLD(hold), .O_SAVE_REQ(sreq), .O_WAKE(wake));
	task automatic results();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic rst(input int n);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (n) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
	endtask
	// APB write held until pready is sampled; returns at the falling edge so state has settled
	task automatic bus(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{1'b1, 1'b0, 1'b1, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		err = rsp.pslverr;
		req <= '0;
		@(negedge clk);
		chk(n < 20, "no pready");
		if (n >= 20)
			results();
	endtask
	task automatic go(input int b, input logic [1:0] e, input string m);
		bus(CMD_OFFSET, 32'h1 << b);
		chk(pwr === e, m);
	endtask
	// Short timer load keeps the idle countdown brief
	task automatic t_timer();
		int n;
		rst(2);
		chk(pwr === OFF_STATE, "reset");
		bus(TIMER_OFFSET, 32'h8);
		go(CMD_OPEN_BIT, FULL_ON_STATE, "open");
		go(CMD_CLOSE_BIT, LOSSY_LOW_POWER_STATE, "close");
		n = 0;
		while (pwr !== OFF_STATE && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(n >= 8 && n <= 12, "expiry");
		go(CMD_OPEN_BIT, FULL_ON_STATE, "reopen");
		go(CMD_CLOSE_BIT, LOSSY_LOW_POWER_STATE, "close 2");
		go(CMD_OPEN_BIT, FULL_ON_STATE, "quick open");
		repeat (20) @(negedge clk);
		chk(pwr === FULL_ON_STATE, "timer cancel");
		$display("Timer test done");
	endtask
	task automatic t_pause();
		rst(2);
		bus(CTRL_OFFSET, 32'h9);
		go(CMD_OPEN_BIT, FULL_ON_STATE, "open");
		go(CMD_PAUSE_BIT, RETAIN_LOW_POWER_STATE, "retain");
		chk(hold === 1'b1, "hold");
		go(CMD_RESUME_BIT, FULL_ON_STATE, "resume");
		bus(CTRL_OFFSET, 32'h8);
		go(CMD_PAUSE_BIT, LOSSY_LOW_POWER_STATE, "lossy");
		repeat (20) @(negedge clk);
		go(CMD_POWER_DOWN_BIT, LOSSY_LOW_POWER_STATE, "save first");
		chk(sreq === 1'b1, "save req");
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		@(negedge clk);
		chk(pwr === OFF_STATE && sreq === 1'b0, "saved off");
		go(CMD_RESUME_BIT, FULL_ON_STATE, "resume off");
		$display("Pause test done");
	endtask
	task automatic t_refuse();
		rst(2);
		bus(CTRL_OFFSET, 32'h8);
		go(CMD_OPEN_BIT, FULL_ON_STATE, "open");
		go(CMD_POWER_DOWN_BIT, FULL_ON_STATE, "play off");
		bus(CTRL_OFFSET, 32'h10);
		go(CMD_POWER_DOWN_BIT, FULL_ON_STATE, "fg off");
		bus(CTRL_OFFSET, 32'h14);
		go(CMD_PAUSE_BIT, FULL_ON_STATE, "bg pause");
		bus(CTRL_OFFSET, 32'h1c);
		go(CMD_POWER_DOWN_BIT, FULL_ON_STATE, "bg yields");
		bus(CTRL_OFFSET, 32'h14);
		go(CMD_POWER_DOWN_BIT, OFF_STATE, "bg off");
		bus(CTRL_OFFSET, 32'h2);
		bus(CMD_OFFSET, 32'h1 << CMD_WAKE_BIT);
		chk(wake === 1'b1, "wake");
		bus(12'h010, 32'h1);
		chk(err === 1'b1 && pwr === OFF_STATE, "unmapped");
		$display("Refusal test done");
	endtask
	initial begin
		rst(8);
		t_timer();
		t_pause();
		t_refuse();
		results();
	end
endmodule // apsm_top_tb
